// ### hdl/pb_volume_assign.sv
// push-button volume assignment: registers, press stepping, hold and ramp
// assumes debounced active-high button levels on the multipurpose pins
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module pb_volume_assign #(
   parameter int MS_CYCLES = pb_vol_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // avalon-mm slave
   input wire logic [8:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // multipurpose pins carrying the buttons
   input wire logic vol_up_pin,
   input wire logic vol_down_pin,
   // converter control
   output logic [8:0] button_level,
   output logic [5:0] converter_follow,
   output logic button_active
);
   // ***************************************************
   // declarations
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HELD = 3'b010,
      ST_RAMP = 3'b100
   } btn_state_t;

   localparam int MS_W = $clog2(MS_CYCLES + 1);
   localparam logic [8:0] ASSIGN_ADDR = {pb_vol_pkg::ASSIGN_IDX[6:0], 2'b00};
   localparam logic [8:0] SETUP_ADDR = {pb_vol_pkg::SETUP_IDX[6:0], 2'b00};
   localparam logic [8:0] STATUS_ADDR = {pb_vol_pkg::STATUS_IDX[6:0], 2'b00};

   btn_state_t state_q, state_d;
   logic ack_q;
   logic [7:0] assign_q, setup_q;
   logic setup_written_q;
   logic [1:0] pin_sync;
   logic up_s, dn_s, up_prev_q, dn_prev_q;
   logic press_up, press_dn, press;
   logic dir_up_q, held_level;
   logic en, en_prev_q;
   logic [MS_W-1:0] ms_cnt_q;
   logic ms_tick;
   logic [11:0] hold_ms_q, hold_limit;
   logic [11:0] acc_q, acc_sum;
   logic ramp_step;
   logic [2:0] tgt;
   logic [3:0] step_units;
   logic [5:0] follow_d;
   logic [8:0] level_q, level_d;
   logic [31:0] status_word;

   assign tgt = assign_q[pb_vol_pkg::TGT_LSB +: 3];
   assign en = (tgt != pb_vol_pkg::TGT_NONE);
   assign step_units = pb_vol_pkg::STEP_UNITS[assign_q[pb_vol_pkg::STEP_LSB +: 2]];
   assign hold_limit = pb_vol_pkg::HOLD_MS[setup_q[pb_vol_pkg::HOLD_LSB +: 3]];

   // ***************************************************
   // register slave
   // ***************************************************
   // one wait cycle per access; read data captured while waiting
   assign waitrequest = (read | write) & ~ack_q;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
      end
   end

   assign status_word = {10'h000, follow_d, 5'h00, state_q == ST_HELD, state_q == ST_RAMP, level_q};

   // read mux, unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack_q) begin
         case (address)
            ASSIGN_ADDR: readdata <= {24'h00_0000, assign_q};
            SETUP_ADDR: readdata <= {24'h00_0000, setup_q};
            STATUS_ADDR: readdata <= status_word;
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         assign_q <= pb_vol_pkg::ASSIGN_RESET;
      end else if (write && ack_q && byteenable[0] && address == ASSIGN_ADDR) begin
         assign_q <= writedata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         setup_q <= pb_vol_pkg::SETUP_RESET;
         setup_written_q <= 1'b0;
      end else if (write && ack_q && byteenable[0] && address == SETUP_ADDR) begin
         setup_q <= writedata[7:0];
         setup_written_q <= 1'b1;
      end
   end

   // ***************************************************
   // button inputs
   // ***************************************************
   pb_pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .clock(clock),
      .reset_n(reset_n),
      .pin_async({vol_down_pin, vol_up_pin}),
      .pin_sync(pin_sync)
   );

   assign up_s = pin_sync[0];
   assign dn_s = pin_sync[1];

   // edge memory for press detection
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         up_prev_q <= 1'b0;
         dn_prev_q <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         up_prev_q <= up_s;
         dn_prev_q <= dn_s;
         en_prev_q <= en;
      end
   end

   // both buttons together is ambiguous, so neither counts
   assign press_up = en && up_s && !up_prev_q && !dn_s && state_q == ST_IDLE;
   assign press_dn = en && dn_s && !dn_prev_q && !up_s && state_q == ST_IDLE;
   assign press = press_up | press_dn;
   assign held_level = dir_up_q ? up_s : dn_s;

   // ***************************************************
   // millisecond divider
   // ***************************************************
   always_ff @(posedge clock) begin
      if (!reset_n || state_q == ST_IDLE) begin
         ms_cnt_q <= '0;
      end else if (ms_cnt_q == MS_W'(MS_CYCLES - 1)) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_cnt_q + 1'b1;
      end
   end

   assign ms_tick = (state_q != ST_IDLE) && (ms_cnt_q == MS_W'(MS_CYCLES - 1));

   // ***************************************************
   // press, hold and ramp sequence
   // ***************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (press) begin
               state_d = ST_HELD;
            end
         end
         ST_HELD: begin
            if (!held_level || !en) begin
               state_d = ST_IDLE;
            end else if (ms_tick && hold_ms_q + 12'h001 >= hold_limit) begin
               state_d = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (!held_level || !en) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         dir_up_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (press) begin
            dir_up_q <= press_up;
         end
      end
   end

   // held time in ms since the press
   always_ff @(posedge clock) begin
      if (!reset_n || state_q != ST_HELD) begin
         hold_ms_q <= 12'h000;
      end else if (ms_tick) begin
         hold_ms_q <= hold_ms_q + 12'h001;
      end
   end

   // rate accumulator, exact for every code
   assign acc_sum = acc_q + (12'(pb_vol_pkg::RAMP_DBPS[assign_q[pb_vol_pkg::RAMP_LSB +: 3]])
                    << pb_vol_pkg::RAMP_ACC_SHIFT);
   assign ramp_step = (state_q == ST_RAMP) && ms_tick && (acc_sum >= pb_vol_pkg::RAMP_ACC_LIMIT);

   always_ff @(posedge clock) begin
      if (!reset_n || state_q != ST_RAMP) begin
         acc_q <= 12'h000;
      end else if (ms_tick) begin
         acc_q <= ramp_step ? acc_sum - pb_vol_pkg::RAMP_ACC_LIMIT : acc_sum;
      end
   end

   // ***************************************************
   // shared level (attenuation in 0.375 dB units)
   // ***************************************************
   function automatic logic [8:0] move(input logic [8:0] lvl, input logic [3:0] amt, input logic up);
      logic [9:0] sum;
      sum = {1'b0, lvl} + {6'h00, amt};
      if (up) begin
         move = (lvl > {5'h00, amt}) ? lvl - {5'h00, amt} : 9'h000;
      end else begin
         move = (sum > {1'b0, pb_vol_pkg::LEVEL_MUTE}) ? pb_vol_pkg::LEVEL_MUTE : sum[8:0];
      end
   endfunction

   always_comb begin
      level_d = level_q;
      if (en && !en_prev_q) begin
         level_d = setup_written_q ?
                   9'(setup_q[pb_vol_pkg::START_LSB +: 5]) << pb_vol_pkg::START_UNIT_SHIFT :
                   pb_vol_pkg::LEVEL_MUTE;
      end else if (press) begin
         level_d = move(level_q, step_units, press_up);
      end else if (ramp_step) begin
         level_d = move(level_q, 4'h1, dir_up_q);
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         level_q <= pb_vol_pkg::LEVEL_MUTE;
      end else begin
         level_q <= level_d;
      end
   end

   // ***************************************************
   // converter selection
   // ***************************************************
   // per-converter target decode
   for (genvar i = 0; i < pb_vol_pkg::NUM_CONV; i++) begin : g_conv
      if (i < 2) begin : g_adc_lo
         assign follow_d[i] = (tgt == pb_vol_pkg::TGT_ADC01) || (tgt == pb_vol_pkg::TGT_ADC_ALL);
      end else if (i < 4) begin : g_adc_hi
         assign follow_d[i] = (tgt == pb_vol_pkg::TGT_ADC23) || (tgt == pb_vol_pkg::TGT_ADC_ALL);
      end else begin : g_dac
         assign follow_d[i] = (tgt == pb_vol_pkg::TGT_DAC_BOTH) ||
                              (tgt == ((i == 4) ? pb_vol_pkg::TGT_DAC0 : pb_vol_pkg::TGT_DAC1));
      end
   end

   // one shared level moves whole group
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         converter_follow <= 6'h00;
         button_active <= 1'b0;
      end else begin
         converter_follow <= follow_d;
         button_active <= en;
      end
   end

   assign button_level = level_q;

   // ***************************************************
   // checks
   // ***************************************************
   property p_step;
      @(posedge clock) disable iff (!reset_n)
      (press_up && en_prev_q && level_q > 9'h00C) |=> (level_q == $past(level_q) - 9'($past(step_units)));
   endproperty
   a_step: assert property (p_step) else $error("press did not move level by one step");

   property p_ramp;
      @(posedge clock) disable iff (!reset_n)
      (state_q == ST_RAMP && !ms_tick && !(en && !en_prev_q)) |=> (level_q == $past(level_q));
   endproperty
   a_ramp: assert property (p_ramp) else $error("level moved between ramp ticks");

   property p_off;
      @(posedge clock) disable iff (!reset_n)
      (tgt == pb_vol_pkg::TGT_NONE) |=> (converter_follow == 6'h00 && !button_active);
   endproperty
   a_off: assert property (p_off) else $error("converter follows while feature is off");

   property p_all_adc;
      @(posedge clock) disable iff (!reset_n)
      (tgt == pb_vol_pkg::TGT_ADC_ALL) |=> (converter_follow == 6'h0F);
   endproperty
   a_all_adc: assert property (p_all_adc) else $error("all-ADC target decoded wrongly");

   property p_reset;
      @(posedge clock)
      !reset_n |=> (assign_q == 8'h87 && converter_follow == 6'h00);
   endproperty
   a_reset: assert property (p_reset) else $error("assignment register not at reset value");

   property p_start;
      @(posedge clock) disable iff (!reset_n)
      (en && !en_prev_q && setup_written_q) |=> (level_q == 9'({$past(setup_q[7:3]), 2'b00}));
   endproperty
   a_start: assert property (p_start) else $error("start level not code times 1.5 dB");

   property p_hold;
      @(posedge clock) disable iff (!reset_n)
      (state_q == ST_HELD && state_d == ST_RAMP) |-> (hold_ms_q + 12'h001 >= hold_limit && ms_tick);
   endproperty
   a_hold: assert property (p_hold) else $error("ramp began before hold time");

   property p_pair;
      @(posedge clock) disable iff (!reset_n)
      ##1 (converter_follow[0] == converter_follow[1] && converter_follow[2] == converter_follow[3]);
   endproperty
   a_pair: assert property (p_pair) else $error("ADC pair members split");
endmodule // pb_volume_assign

// ### hdl/pb_vol_pkg.sv
// constants for the push-button volume assignment block
// assumes a 125 MHz single clock and an Avalon-MM register slave
package pb_vol_pkg;
   // ***************************************************
   // register map (printed offsets are word indices)
   // ***************************************************
   localparam logic [7:0] SETUP_IDX = 8'h3F;
   localparam logic [7:0] ASSIGN_IDX = 8'h40;
   localparam logic [7:0] STATUS_IDX = 8'h44;
   localparam logic [7:0] ASSIGN_RESET = 8'h87;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int STEP_LSB = 6;
   localparam int RAMP_LSB = 3;
   localparam int TGT_LSB = 0;
   localparam int START_LSB = 3;
   localparam int HOLD_LSB = 0;
   localparam int STAT_RAMP_BIT = 9;
   localparam int STAT_HELD_BIT = 10;
   localparam int STAT_FOLLOW_LSB = 16;
   // ***************************************************
   // target codes and level scale (unit = 0.375 dB)
   // ***************************************************
   localparam logic [2:0] TGT_ADC01 = 3'h0;
   localparam logic [2:0] TGT_ADC23 = 3'h1;
   localparam logic [2:0] TGT_ADC_ALL = 3'h2;
   localparam logic [2:0] TGT_DAC_BOTH = 3'h3;
   localparam logic [2:0] TGT_DAC0 = 3'h4;
   localparam logic [2:0] TGT_DAC1 = 3'h5;
   localparam logic [2:0] TGT_NONE = 3'h7;
   localparam int LEVEL_W = 9;
   localparam int NUM_CONV = 6;
   localparam logic [8:0] LEVEL_MUTE = 9'h100;
   localparam int START_UNIT_SHIFT = 2;
   localparam logic [3:0] STEP_UNITS [0:3] = '{4'h1, 4'h4, 4'h8, 4'hC};
   localparam logic [7:0] RAMP_DBPS [0:7] = '{8'h3C, 8'h30, 8'h24, 8'h1E, 8'h18, 8'h12, 8'h0C, 8'h06};
   localparam logic [11:0] HOLD_MS [0:7] =
      '{12'h096, 12'h12C, 12'h1C2, 12'h258, 12'h384, 12'h4B0, 12'h4B0, 12'h4B0};
   // accumulator adds dB/s times 8 each ms; one unit per 3000 = 0.375 dB times 8 times 1000 ms per second
   localparam int RAMP_ACC_SHIFT = 3;
   localparam logic [11:0] RAMP_ACC_LIMIT = 12'h0BB8;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLOCK_MHZ = 125;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
endpackage

// ### hdl/pb_pin_sync.sv
// two-flop synchroniser for the button pins
// assumes pins are asynchronous to clock
`timescale 1ns/1ns
module pb_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // pins and synchronised copy
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         meta_q <= '0;
         pin_sync <= '0;
      end else begin
         meta_q <= pin_async;
         pin_sync <= meta_q;
      end
   end
endmodule // pb_pin_sync

// ### test/pb_button_model.sv
// button model: two debounced push buttons wired to the multipurpose pins
// assumes the bench commands press and release levels just after a clock edge
`timescale 1ns/1ns
module pb_button_model (
   // clock
   input wire logic clock,
   // press commands from the bench
   input wire logic up_cmd,
   input wire logic down_cmd,
   // button pins, pulled low while released
   output logic vol_up_pin,
   output logic vol_down_pin
);
   // released buttons sit at the pull-down level from time zero
   initial begin
      vol_up_pin = 1'b0;
      vol_down_pin = 1'b0;
   end
   // contacts move one edge after the command, already debounced
   always @(posedge clock) begin
      vol_up_pin <= up_cmd;
      vol_down_pin <= down_cmd;
   end
endmodule // pb_button_model

// ### test/tb_top.sv
// self-checking bench for the push-button volume assignment block
// assumes the millisecond tick is shortened to 10 cycles; all ms figures scale
`timescale 1ns/1ns
module tb_top;
   // ************************************
   // signals and settings
   // ************************************
   localparam int MSC = 10;
   localparam logic [8:0] A_SETUP = 9'h0FC;
   localparam logic [8:0] A_ASSIGN = 9'h100;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [8:0] address = 9'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   logic up_cmd = 1'b0;
   logic down_cmd = 1'b0;
   logic vol_up_pin;
   logic vol_down_pin;
   logic [8:0] button_level;
   logic [5:0] converter_follow;
   logic button_active;
   int errors = 0;
   int num_checks = 0;
   int seed = 22;
   logic [31:0] rd;
   logic [8:0] lvl, l1, l2;
   int s, h, r;

   // 125 MHz clock
   always #4 clock = ~clock;

   pb_volume_assign #(.MS_CYCLES(MSC)) i_pb_volume_assign (.clock(clock), .reset_n(reset_n),
      .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .vol_up_pin(vol_up_pin), .vol_down_pin(vol_down_pin),
      .button_level(button_level), .converter_follow(converter_follow), .button_active(button_active));
   pb_button_model i_pb_button_model (.clock(clock), .up_cmd(up_cmd), .down_cmd(down_cmd),
      .vol_up_pin(vol_up_pin), .vol_down_pin(vol_down_pin));

   // ************************************
   // expectations: steps in 0.375 dB units, ramp rates in dB/s, hold times in ms
   // ************************************
   function automatic logic [5:0] follow_exp(input logic [2:0] t);
      case (t)
         3'h0: return 6'h03;
         3'h1: return 6'h0C;
         3'h2: return 6'h0F;
         3'h3: return 6'h30;
         3'h4: return 6'h10;
         3'h5: return 6'h20;
         default: return 6'h00;
      endcase
   endfunction
   function automatic int step_exp(input int g);
      return (g == 0) ? 1 : g * 4;
   endfunction
   function automatic int ramp_dbps(input int c);
      int t [8] = '{60, 48, 36, 30, 24, 18, 12, 6};
      return t[c];
   endfunction
   function automatic int hold_ms(input int c);
      int t [8] = '{150, 300, 450, 600, 900, 1200, 1200, 1200};
      return t[c];
   endfunction

   // ************************************
   // bus cycles and stimulus
   // ************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // request held until waitrequest is sampled low; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge clock);
      address <= a;
      writedata <= {24'h00_0000, d};
      byteenable <= be;
      if (wr) write <= 1'b1;
      else read <= 1'b1;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // short press, far below the shortest hold time
   task automatic press(input logic up, input logic dn);
      @(posedge clock);
      up_cmd <= up;
      down_cmd <= dn;
      cyc(20);
      up_cmd <= 1'b0;
      down_cmd <= 1'b0;
      cyc(20);
   endtask

   // ************************************
   // comparisons and verdict
   // ************************************
   task automatic fail(input string m);
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic check_reg(input logic [31:0] exp);
      num_checks++;
      if (rd !== exp) fail($sformatf("register %h, expected %h", rd, exp));
   endtask
   task automatic check_level(input logic [8:0] exp);
      num_checks++;
      if (button_level !== exp) fail($sformatf("level %h, expected %h", button_level, exp));
   endtask
   task automatic check_follow(input logic act, input logic [5:0] exp);
      num_checks++;
      if (button_active !== act || converter_follow !== exp) fail("follow mask or active flag wrong");
   endtask
   task automatic check_span(input logic [8:0] a, input logic [8:0] b, input int lo, input int hi);
      num_checks++;
      if ($isunknown({a, b}) || int'(b) - int'(a) < lo || int'(b) - int'(a) > hi)
         fail($sformatf("ramp moved %h to %h, expected %0d..%0d units", a, b, lo, hi));
   endtask
   task automatic final_report;
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog: the run needs under 30k cycles, so 60k means a hang
   initial begin
      cyc(60000);
      fail("timeout");
      final_report();
   end

   // ************************************
   // main sequence
   // ************************************
   initial begin
      cyc(16);
      reset_n <= 1'b1;
      bus(1'b0, A_ASSIGN, 8'h00, 4'hF);
      check_reg(8'h87);
      bus(1'b0, A_SETUP, 8'h00, 4'hF);
      check_reg(8'h00);
      bus(1'b0, 9'h1F0, 8'h00, 4'hF);
      check_reg(8'h00);
      check_level(9'h100);
      check_follow(1'b0, 6'h00);
      // enabled before any setup write: start at the mute level
      bus(1'b1, A_ASSIGN, 8'h80, 4'hF);
      cyc(2);
      check_level(9'h100);
      bus(1'b1, A_ASSIGN, 8'h45, 4'hE);
      bus(1'b0, A_ASSIGN, 8'h00, 4'hF);
      check_reg(8'h80);
      // every target code, then presses with the feature off are ignored
      for (int t = 0; t < 8; t++) begin
         bus(1'b1, A_ASSIGN, {5'h10, 3'(t)}, 4'hF);
         cyc(2);
         check_follow(t != 7, follow_exp(3'(t)));
      end
      lvl = button_level;
      press(1'b1, 1'b0);
      check_level(lvl);
      // software sets the start level before enabling
      for (int g = 0; g < 4; g++) begin
         s = (g == 0) ? 0 : ($random(seed) & 31);
         bus(1'b1, A_SETUP, {5'(s), 3'h0}, 4'hF);
         bus(1'b1, A_ASSIGN, {2'(g), 6'h07}, 4'hF);
         bus(1'b1, A_ASSIGN, {2'(g), 3'($random(seed)), 3'h2}, 4'hF);
         cyc(2);
         lvl = 9'(s * 4);
         check_level(lvl);
         press(1'b1, 1'b0);
         lvl = (lvl < step_exp(g)) ? 9'h000 : 9'(lvl - step_exp(g));
         check_level(lvl);
         press(1'b0, 1'b1);
         press(1'b0, 1'b1);
         lvl = 9'(lvl + 2 * step_exp(g));
         check_level(lvl);
         press(1'b1, 1'b1);
         check_level(lvl);
      end
      // held button: no ramp before the hold time, then the coded rate
      for (int k = 0; k < 2; k++) begin
         r = (k == 0) ? 0 : 1 + ($unsigned($random(seed)) % 7);
         h = $unsigned($random(seed)) % 6;
         bus(1'b1, A_SETUP, {5'h10, 3'(h)}, 4'hF);
         bus(1'b1, A_ASSIGN, 8'h07, 4'hF);
         bus(1'b1, A_ASSIGN, {2'h1, 3'(r), 3'h3}, 4'hF);
         @(posedge clock);
         down_cmd <= 1'b1;
         cyc(hold_ms(h) * MSC - 50);
         check_level(9'h044);
         // status: both DACs follow, held flag up, not yet ramping
         bus(1'b0, 9'h110, 8'h00, 4'hF);
         check_reg(32'h0030_0444);
         cyc(150);
         l1 = button_level;
         cyc(100 * MSC);
         l2 = button_level;
         check_span(l1, l2, ramp_dbps(r) * 4 / 15 - 1, ramp_dbps(r) * 4 / 15 + 1);
         down_cmd <= 1'b0;
         cyc(10);
         lvl = button_level;
         cyc(300);
         check_level(lvl);
      end
      final_report();
   end
endmodule // tb_top
